/* pll_ratio_and_system_control_tb.sv */
// Self-checking testbench of the clock control block.
`timescale 1ns/1ps
`include "sysctl_defines.svh"

module pll_ratio_and_system_control_tb
	import sysctl_pkg::*;
;
	localparam int XDIV = 8;

	logic                sys_clk = 1'b0;
	logic                rst = 1'b1;
	logic                debug_reset = 1'b0;
	logic                prot_unlock = 1'b0;
	logic [`ADDR_W-1:0]  bus_addr = '0;
	logic                bus_we = 1'b0;
	logic                bus_re = 1'b0;
	logic [`DATA_W-1:0]  bus_wdata = '0;
	logic [`DATA_W-1:0]  bus_rdata;
	logic                bus_rvalid;
	logic                write_blocked;
	logic [`RATIO_W-1:0] pll_ratio;
	logic                pll_bypass;
	logic                cpu_clk_en;
	logic                sysclk_out_en;
	int                  miscompares = 0;
	int                  samples_checked = 0;
	logic [`ADDR_W-1:0]  words [8] = '{`OFS_HS_PRESCALE, `OFS_LS_PRESCALE, `OFS_CLOCK_GATE,
		`OFS_LOW_POWER_0, `OFS_LOW_POWER_1, `OFS_SYS_STATUS, `OFS_WD_KEY, `OFS_WD_CONTROL};

	always #5 sys_clk = ~sys_clk;

	sysctl_top #(.XCLK_DIV(XDIV)) uut (
		.SYS_CLK       (sys_clk),
		.RST           (rst),
		.DEBUG_RESET   (debug_reset),
		.PROT_UNLOCK   (prot_unlock),
		.BUS_ADDR      (bus_addr),
		.BUS_WE        (bus_we),
		.BUS_RE        (bus_re),
		.BUS_WDATA     (bus_wdata),
		.BUS_RDATA     (bus_rdata),
		.BUS_RVALID    (bus_rvalid),
		.WRITE_BLOCKED (write_blocked),
		.PLL_RATIO     (pll_ratio),
		.PLL_BYPASS    (pll_bypass),
		.CPU_CLK_EN    (cpu_clk_en),
		.SYSCLK_OUT_EN (sysclk_out_en)
	);

	// ==========================================================================
	// Bus cycles and comparison
	// ==========================================================================
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask

	// Each bus task starts and ends at a falling edge, with one idle cycle after the access.
	task automatic wr(input logic [21:0] a, input logic [15:0] d, input logic unl,
		input logic blk);
		bus_addr = a;
		bus_wdata = d;
		prot_unlock = unl;
		bus_we = 1'b1;
		@(negedge sys_clk);
		check({15'h0000, write_blocked}, {15'h0000, blk});
		bus_we = 1'b0;
		prot_unlock = 1'b0;
		@(negedge sys_clk);
		check({15'h0000, write_blocked}, 16'h0000);
	endtask

	task automatic rd(input logic [21:0] a, input logic [15:0] exp);
		bus_addr = a;
		bus_re = 1'b1;
		@(negedge sys_clk);
		bus_re = 1'b0;
		check({15'h0000, bus_rvalid}, 16'h0001);
		check(bus_rdata, exp);
		@(negedge sys_clk);
		check({15'h0000, bus_rvalid}, 16'h0000);
		check(bus_rdata, exp);
	endtask

	task automatic check_ratio(input logic [3:0] code);
		check({12'h000, pll_ratio}, {12'h000, code});
		check({15'h0000, pll_bypass}, {15'h0000, code == 4'h0});
		rd(`OFS_PLL_RATIO, {12'h000, code});
	endtask

	task automatic end_of_test;
		$display("Compared %0d values, %0d wrong", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ==========================================================================
	// Scenarios
	// ==========================================================================
	task automatic reset_state;
		check_ratio(4'h0);
		for (int i = 0; i < 8; i++) begin
			rd(words[i], `REG_RESET);
		end
	endtask

	task automatic locked_writes;
		wr(`OFS_PLL_RATIO, 16'h0007, 1'b0, 1'b1);
		check_ratio(4'h0);
		wr(`OFS_WD_CONTROL, 16'h00E8, 1'b0, 1'b1);
		rd(`OFS_WD_CONTROL, 16'h0000);
		wr(22'h007020, 16'h1234, 1'b0, 1'b0);
		rd(22'h007020, 16'h0000);
	endtask

	task automatic open_writes;
		for (int i = 0; i < 8; i++) begin
			wr(words[i], {12'hC3A, 4'(i)}, 1'b1, 1'b0);
		end
		for (int i = 0; i < 8; i++) begin
			rd(words[i], {12'hC3A, 4'(i)});
		end
		wr(`OFS_WD_COUNT, 16'h00FF, 1'b1, 1'b0);
		rd(`OFS_WD_COUNT, 16'h0000);
		wr(`OFS_PLL_RATIO, 16'hFFF5, 1'b1, 1'b0);
		check_ratio(4'h5);
	endtask

	// A write in the same cycle as the debug reset must be dropped as well.
	task automatic debug_reset_keeps_ratio;
		debug_reset = 1'b1;
		wr(`OFS_HS_PRESCALE, 16'h0F0F, 1'b1, 1'b0);
		debug_reset = 1'b0;
		check_ratio(4'h5);
		rd(`OFS_HS_PRESCALE, 16'h0000);
		rd(`OFS_WD_KEY, 16'h0000);
	endtask

	task automatic rate(input logic [3:0] code);
		int n;
		int cnt;
		int diff;
		n = (code == 4'h0 || code > 4'hA) ? 1 : int'(code);
		cnt = 0;
		diff = 0;
		wr(`OFS_PLL_RATIO, {12'hABC, code}, 1'b1, 1'b0);
		check_ratio(code);
		repeat (40) @(negedge sys_clk);
		repeat (2 * XDIV * 10) begin
			@(negedge sys_clk);
			if (cpu_clk_en === 1'b1) cnt++;
			if (sysclk_out_en !== cpu_clk_en) diff++;
		end
		check(16'(cnt), 16'(10 * n));
		check(16'(diff), 16'h0000);
	endtask

	task automatic pin_reset;
		rst = 1'b1;
		@(negedge sys_clk);
		rst = 1'b0;
		check({14'h0000, cpu_clk_en, sysclk_out_en}, 16'h0000);
		check_ratio(4'h0);
	endtask

	initial begin
		repeat (6) @(negedge sys_clk);
		rst = 1'b0;
		reset_state();
		locked_writes();
		open_writes();
		debug_reset_keeps_ratio();
		for (int c = 0; c < 16; c++) begin
			rate(4'(c));
		end
		pin_reset();
		end_of_test();
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		end_of_test();
	end
endmodule

/* ratio_rate_gen.sv */
// Fractional enable generator that turns a ratio code into system clock enable pulses.
`timescale 1ns/1ps
`include "sysctl_defines.svh"

module ratio_rate_gen
	import sysctl_pkg::*;
#(
	parameter int XCLK_DIV = `XCLK_DIV_DEFAULT
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic [`RATIO_W-1:0]  ratio,
	output logic                      tick
);

	localparam logic [`ACC_W-1:0] DEN = `ACC_W'(2 * XCLK_DIV);

	logic [`ACC_W-1:0] acc_reg;
	logic [`ACC_W-1:0] acc_next;
	logic              tick_reg;
	logic              tick_next;
	logic [`ACC_W-1:0] step;
	logic [`ACC_W-1:0] sum;

	// ======================================================================
	// Accumulator
	// ======================================================================
	// One reference cycle stands for 1/XCLK_DIV of an input clock period, so
	// adding n per cycle against 2*XCLK_DIV gives input*n/2. Bypass and the
	// reserved codes add one, which gives input/2.
	always_comb begin
		if (ratio == `RATIO_BYPASS || ratio > `RATIO_MAX) begin
			step = `ACC_W'(1);
		end else begin
			step = `ACC_W'(ratio);
		end
		sum = acc_reg + step;
		if (sum >= DEN) begin
			acc_next  = sum - DEN;
			tick_next = 1'b1;
		end else begin
			acc_next  = sum;
			tick_next = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			acc_reg  <= '0;
			tick_reg <= 1'b0;
		end else begin
			acc_reg  <= acc_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;

	// ======================================================================
	// Checks
	// ======================================================================
	acc_bound_a: assert property (@(posedge clk) disable iff (rst)
		acc_reg < DEN)
		else $error("rate accumulator out of range");

	bypass_rate_a: assert property (@(posedge clk) disable iff (rst)
		(tick_reg && ratio == `RATIO_BYPASS && $stable(ratio)) |=> !tick_reg)
		else $error("bypass rate produced back to back ticks");

endmodule

/* sysctl_defines.svh */
// Register offsets, field positions, reset values and rate constants of the clock control block.
`ifndef SYSCTL_DEFINES_SVH
`define SYSCTL_DEFINES_SVH

// ==========================================================================
// Register word addresses
// ==========================================================================
`define ADDR_W              22
`define OFS_HS_PRESCALE     22'h00701A
`define OFS_LS_PRESCALE     22'h00701B
`define OFS_CLOCK_GATE      22'h00701C
`define OFS_LOW_POWER_0     22'h00701E
`define OFS_LOW_POWER_1     22'h00701F
`define OFS_PLL_RATIO       22'h007021
`define OFS_SYS_STATUS      22'h007022
`define OFS_WD_COUNT        22'h007023
`define OFS_WD_KEY          22'h007025
`define OFS_WD_CONTROL      22'h007029

// ==========================================================================
// Fields and reset values
// ==========================================================================
`define DATA_W              16
`define RATIO_W             4
`define RATIO_LSB           0
`define RATIO_MSB           3
`define RATIO_RESET         4'h0
`define RATIO_BYPASS        4'h0
`define RATIO_MAX           4'hA
`define REG_RESET           16'h0000

// ==========================================================================
// Rate generation
// ==========================================================================
`define XCLK_DIV_DEFAULT    8
`define ACC_W               8
`endif

/* sysctl_pkg.sv */
// Types shared by the clock control block.
package sysctl_pkg;

	// Register select; codes 0 to 7 index the plain storage words.
	typedef enum logic [3:0] {
		SEL_HS_PRESCALE = 4'b0000,
		SEL_LS_PRESCALE = 4'b0001,
		SEL_CLOCK_GATE  = 4'b0010,
		SEL_LOW_POWER_0 = 4'b0011,
		SEL_LOW_POWER_1 = 4'b0100,
		SEL_SYS_STATUS  = 4'b0101,
		SEL_WD_KEY      = 4'b0110,
		SEL_WD_CONTROL  = 4'b0111,
		SEL_PLL_RATIO   = 4'b1000,
		SEL_WD_COUNT    = 4'b1001,
		SEL_NONE        = 4'b1111
	} reg_sel_t;

endpackage

/* sysctl_top.sv */
// System clock control: protected register map, PLL ratio register and clock enables.
//
// Function
// - The CPU clock enable and the system clock output enable are one and the same pulse.
// - Writes to any register of the map take effect only while the protected-write unlock is on.
// - Only the external reset pin returns the PLL ratio register to its reset value.
// - A debug emulation reset leaves the PLL ratio register unchanged.
// - The multiplication ratio is taken from bits 3 to 0 of the PLL ratio register.
// - Codes 1 to 10 give input times n over two, code 0 gives input over two, 11 to 15 are reserved.
`timescale 1ns/1ps
`include "sysctl_defines.svh"

module sysctl_top
	import sysctl_pkg::*;
#(
	parameter int XCLK_DIV = `XCLK_DIV_DEFAULT
) (
	input  wire logic                 SYS_CLK,
	input  wire logic                 RST,
	input  wire logic                 DEBUG_RESET,
	input  wire logic                 PROT_UNLOCK,
	input  wire logic [`ADDR_W-1:0]   BUS_ADDR,
	input  wire logic                 BUS_WE,
	input  wire logic                 BUS_RE,
	input  wire logic [`DATA_W-1:0]   BUS_WDATA,
	output logic      [`DATA_W-1:0]   BUS_RDATA,
	output logic                      BUS_RVALID,
	output logic                      WRITE_BLOCKED,
	output logic      [`RATIO_W-1:0]  PLL_RATIO,
	output logic                      PLL_BYPASS,
	output logic                      CPU_CLK_EN,
	output logic                      SYSCLK_OUT_EN
);

	// ======================================================================
	// Address decoding
	// ======================================================================
	function automatic reg_sel_t decode(input logic [`ADDR_W-1:0] addr);
		reg_sel_t sel;
		sel = SEL_NONE;
		if (addr == `OFS_HS_PRESCALE) begin
			sel = SEL_HS_PRESCALE;
		end else if (addr == `OFS_LS_PRESCALE) begin
			sel = SEL_LS_PRESCALE;
		end else if (addr == `OFS_CLOCK_GATE) begin
			sel = SEL_CLOCK_GATE;
		end else if (addr == `OFS_LOW_POWER_0) begin
			sel = SEL_LOW_POWER_0;
		end else if (addr == `OFS_LOW_POWER_1) begin
			sel = SEL_LOW_POWER_1;
		end else if (addr == `OFS_PLL_RATIO) begin
			sel = SEL_PLL_RATIO;
		end else if (addr == `OFS_SYS_STATUS) begin
			sel = SEL_SYS_STATUS;
		end else if (addr == `OFS_WD_COUNT) begin
			sel = SEL_WD_COUNT;
		end else if (addr == `OFS_WD_KEY) begin
			sel = SEL_WD_KEY;
		end else if (addr == `OFS_WD_CONTROL) begin
			sel = SEL_WD_CONTROL;
		end
		return sel;
	endfunction

	// True for the words held in the plain storage array.
	function automatic logic is_store(input reg_sel_t sel);
		return (sel[3] == 1'b0);
	endfunction

	reg_sel_t sel;
	logic     mapped;
	logic     wr_try;
	logic     wr_ok;

	always_comb begin
		sel    = decode(BUS_ADDR);
		mapped = (sel != SEL_NONE);
		// A debug reset in the same cycle takes precedence over the write.
		wr_try = BUS_WE && mapped && !DEBUG_RESET;
		wr_ok  = wr_try && PROT_UNLOCK;
	end

	// ======================================================================
	// PLL ratio register
	// ======================================================================
	// Its reset is tied to the pin reset alone; the debug reset reaches
	// this process only through wr_ok, by dropping a write in its cycle.
	// Reserved codes are stored and read back as written; only code 0000
	// raises the bypass flag.
	logic [`RATIO_W-1:0] ratio_reg;
	logic [`RATIO_W-1:0] ratio_next;
	logic                bypass_reg;
	logic                bypass_next;

	always_comb begin
		ratio_next = ratio_reg;
		if (wr_ok && sel == SEL_PLL_RATIO) begin
			ratio_next = BUS_WDATA[`RATIO_MSB:`RATIO_LSB];
		end
		bypass_next = (ratio_next == `RATIO_BYPASS);
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ratio_reg  <= `RATIO_RESET;
			bypass_reg <= 1'b1;
		end else begin
			ratio_reg  <= ratio_next;
			bypass_reg <= bypass_next;
		end
	end

	assign PLL_RATIO  = ratio_reg;
	assign PLL_BYPASS = bypass_reg;

	// ======================================================================
	// Remaining protected registers
	// ======================================================================
	// The prescaler, gating, low-power, status and watchdog words are held
	// as plain storage here; the logic they steer lives elsewhere. Both the
	// pin reset and the debug reset clear them.
	// Writes to the watchdog count are dropped, since that word has no
	// storage of its own.
	logic [`DATA_W-1:0] store_reg  [0:7];
	logic [`DATA_W-1:0] store_next [0:7];

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			store_next[i] = store_reg[i];
		end
		if (DEBUG_RESET) begin
			for (int i = 0; i < 8; i++) begin
				store_next[i] = `REG_RESET;
			end
		end else if (wr_ok && is_store(sel)) begin
			store_next[sel[2:0]] = BUS_WDATA;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		for (int i = 0; i < 8; i++) begin
			if (RST) begin
				store_reg[i] <= `REG_RESET;
			end else begin
				store_reg[i] <= store_next[i];
			end
		end
	end

	// ======================================================================
	// Read port and refusal flag
	// ======================================================================
	// Unmapped words and the watchdog count read as zero; reads need no
	// unlock, so software can always see the current ratio.
	logic [`DATA_W-1:0] rdata_reg;
	logic [`DATA_W-1:0] rdata_next;
	logic               rvalid_reg;
	logic               rvalid_next;
	logic               blocked_reg;
	logic               blocked_next;

	always_comb begin
		rdata_next = rdata_reg;
		if (BUS_RE) begin
			if (sel == SEL_PLL_RATIO) begin
				rdata_next = {{(`DATA_W-`RATIO_W){1'b0}}, ratio_reg};
			end else if (is_store(sel)) begin
				rdata_next = store_reg[sel[2:0]];
			end else begin
				rdata_next = `REG_RESET;
			end
		end
		rvalid_next  = BUS_RE;
		blocked_next = wr_try && !PROT_UNLOCK;
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			rdata_reg   <= `REG_RESET;
			rvalid_reg  <= 1'b0;
			blocked_reg <= 1'b0;
		end else begin
			rdata_reg   <= rdata_next;
			rvalid_reg  <= rvalid_next;
			blocked_reg <= blocked_next;
		end
	end

	assign BUS_RDATA     = rdata_reg;
	assign BUS_RVALID    = rvalid_reg;
	assign WRITE_BLOCKED = blocked_reg;

	// ======================================================================
	// Clock enables
	// ======================================================================
	// The rate generator ticks at the input clock rate times n over two,
	// counted in reference cycles. A new ratio takes effect one cycle after
	// it shows on the ratio output, and the enables lag the tick by a cycle.
	logic rate_tick;
	logic cpu_en_reg;
	logic sys_en_reg;
	logic en_next;

	ratio_rate_gen #(
		.XCLK_DIV (XCLK_DIV)
	) u_rate (
		.clk   (SYS_CLK),
		.rst   (RST),
		.ratio (ratio_reg),
		.tick  (rate_tick)
	);

	always_comb begin
		en_next = rate_tick;
	end

	// Both enables come from the same source so they never drift apart.
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			cpu_en_reg <= 1'b0;
			sys_en_reg <= 1'b0;
		end else begin
			cpu_en_reg <= en_next;
			sys_en_reg <= en_next;
		end
	end

	assign CPU_CLK_EN    = cpu_en_reg;
	assign SYSCLK_OUT_EN = sys_en_reg;

	// ======================================================================
	// Checks
	// ======================================================================
	// The checks are off while the pin reset is high; the reset checks
	// look at the first edge after its release, where RST has just fallen.
	clk_same_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		CPU_CLK_EN == SYSCLK_OUT_EN)
		else $error("cpu and system clock enables differ");

	enable_idle_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		$fell(RST) |-> (!CPU_CLK_EN && !SYSCLK_OUT_EN))
		else $error("clock enables active straight after reset");

	lock_guard_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(BUS_WE && !PROT_UNLOCK && sel == SEL_PLL_RATIO) |=> $stable(PLL_RATIO))
		else $error("locked write changed the ratio");

	blocked_flag_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(BUS_WE && mapped && !DEBUG_RESET) |=> (WRITE_BLOCKED == !$past(PROT_UNLOCK)))
		else $error("refusal flag wrong for write");

	ratio_reset_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		$fell(RST) |-> (PLL_RATIO == `RATIO_RESET && PLL_BYPASS))
		else $error("ratio not cleared by pin reset");

	ratio_only_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		$changed(PLL_RATIO) |-> ($past(RST) || $past(wr_ok && sel == SEL_PLL_RATIO)))
		else $error("ratio changed without pin reset or write");

	debug_keep_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		DEBUG_RESET |=> $stable(PLL_RATIO))
		else $error("debug reset altered the ratio");

	ratio_field_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(wr_ok && sel == SEL_PLL_RATIO) |=> PLL_RATIO == $past(BUS_WDATA[3:0]))
		else $error("ratio field not taken from low bits");

	bypass_flag_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		PLL_BYPASS == (PLL_RATIO == `RATIO_BYPASS))
		else $error("bypass flag disagrees with ratio");

	ratio_read_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(BUS_RE && sel == SEL_PLL_RATIO) |=>
			(BUS_RVALID && BUS_RDATA == {12'h000, $past(PLL_RATIO)}))
		else $error("ratio read returned wrong value");

	ratio_high_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		$past(BUS_RE && sel == SEL_PLL_RATIO) |-> (BUS_RDATA[15:4] == 12'h000))
		else $error("ratio read upper bits not zero");

	rvalid_pulse_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		BUS_RVALID == $past(BUS_RE))
		else $error("read valid not one cycle after read strobe");

	store_guard_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(wr_try && !PROT_UNLOCK && is_store(sel)) |=>
			(store_reg[$past(sel[2:0])] == $past(store_reg[sel[2:0]])))
		else $error("locked write changed a protected word");

	store_write_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(wr_ok && is_store(sel)) |=> (store_reg[$past(sel[2:0])] == $past(BUS_WDATA)))
		else $error("unlocked write not stored");

	pll_write_c: cover property (@(posedge SYS_CLK) disable iff (RST)
		wr_ok && sel == SEL_PLL_RATIO && BUS_WDATA[3:0] == 4'hA);

	blocked_c: cover property (@(posedge SYS_CLK) disable iff (RST)
		WRITE_BLOCKED);

	debug_hold_c: cover property (@(posedge SYS_CLK) disable iff (RST)
		DEBUG_RESET && PLL_RATIO != `RATIO_BYPASS);

	fast_tick_c: cover property (@(posedge SYS_CLK) disable iff (RST)
		SYSCLK_OUT_EN && PLL_RATIO == 4'hA);

	reserved_code_c: cover property (@(posedge SYS_CLK) disable iff (RST)
		PLL_RATIO > `RATIO_MAX && SYSCLK_OUT_EN);

endmodule
